// ==== rtl/charge_seq_pkg.sv ====
/*
 constants, states and carriers for the charge phase sequencer.
 assumes a 50 MHz system clock and millivolt / milliamp sample codes.
*/
package charge_seq_pkg;
   // ==========================================================
   // clock and timing
   localparam int unsigned CLK_HZ         = 50_000_000;
   localparam int unsigned CLK_PERIOD_NS  = 20;
   localparam int unsigned SW_FREQ_HZ     = 250_000;
   localparam int unsigned SW_PERIOD_CYC  = CLK_HZ / SW_FREQ_HZ;
   localparam int unsigned OC_TIME_US     = 30_000;
   localparam int unsigned OC_CYC         =
      OC_TIME_US * (CLK_HZ / 1_000_000);
   localparam int unsigned SC_TIME_NS     = 40_000;
   localparam int unsigned SC_CYC         = SC_TIME_NS / CLK_PERIOD_NS;
   localparam int unsigned PERSIST_SAMPLES = 4;
   // ==========================================================
   // thresholds, millivolts and milliamps
   localparam logic [15:0] VBAT_LOW_MV    = 16'h09C4; // 2.5 V absolute
   localparam logic [12:0] EXIT_LI_MV     = 13'h0BB8; // 3.0 V per cell
   localparam logic [12:0] EXIT_LFP_MV    = 13'h09C4; // 2.5 V per cell
   localparam logic [12:0] RECH_DROP_MV   = 13'h0064; // 0.1 V per cell
   localparam logic [12:0] CV_WIN_MV      = 13'h0032; // cv entry window
   localparam logic [15:0] PRE_LOW_MA     = 16'h0064;
   localparam logic [15:0] PRE_HIGH_MA    = 16'h00C8;
   localparam logic [15:0] TERM_MA        = 16'h0064;
   localparam logic [15:0] OC_MV          = 16'h0960; // 2.4 V
   localparam logic [15:0] SC_MV          = 16'h0898; // 2.2 V
   localparam logic [2:0]  CELL_MIN       = 3'h2;
   localparam logic [2:0]  CELL_MAX       = 3'h5;
   // ==========================================================
   // condition vector positions
   localparam int unsigned C_ABOVE_LOW  = 0;
   localparam int unsigned C_ABOVE_EXIT = 1;
   localparam int unsigned C_NEAR_FULL  = 2;
   localparam int unsigned C_TERM_CUR   = 3;
   localparam int unsigned C_DROOP      = 4;
   localparam int unsigned N_COND       = 5;
   // ==========================================================
   // phases, one-hot
   typedef enum logic [4:0] {
      PH_PRE_LOW  = 5'h01,
      PH_PRE_HIGH = 5'h02,
      PH_CC       = 5'h04,
      PH_CV       = 5'h08,
      PH_FULL     = 5'h10
   } phase_t;
   // one adc sample set
   typedef struct packed {
      logic [15:0] vbat_mv;
      logic [15:0] ibat_ma;
      logic [15:0] vout_mv;
   } meas_t;
   // discharge side fault flags
   typedef struct packed {
      logic overcur;
      logic short_ckt;
   } fault_t;
endpackage

// ==== rtl/sample_persist.sv ====
/*
 persistence filter for one threshold condition.
 assumes i_sample is a one-cycle strobe on i_sys_clk.
*/
`timescale 1ns/1ps
module sample_persist
   import charge_seq_pkg::*;
#(
   parameter int unsigned COUNT = PERSIST_SAMPLES
)
(
   input  wire logic i_sys_clk,
   input  wire logic i_rst_n,
   input  wire logic i_sample,
   input  wire logic i_cond,
   output logic      o_level
);
   // ==========================================================
   // run counter
   logic [7:0] run_r;     // samples disagreeing with level
   logic       level_r;   // filtered level

   // a single noisy sample never flips the level
   always_ff @(posedge i_sys_clk)
   begin
      if (!i_rst_n)
      begin
         run_r   <= 8'h00;
         level_r <= 1'b0;
      end
      else if (i_sample)
      begin
         if (i_cond == level_r)
            run_r <= 8'h00;     // agreement restarts run
         else if (run_r == 8'(COUNT - 1))
         begin
            level_r <= i_cond;  // persisted long enough
            run_r   <= 8'h00;
         end
         else
            run_r <= run_r + 8'h01;
      end
   end

   assign o_level = level_r;
endmodule

// ==== rtl/charge_phase_seq.sv ====
/*
 charge phase sequencer with discharge output supervision.
 assumes adc samples arrive on i_sys_clk with a one-cycle strobe;
 the per-cell full voltage and cc current come from setting decode.
*/
// Function
// - at or below 2.5 V: 100 mA precharge
// - above 2.5 V to exit: 200 mA precharge
// - exit level: N*3 V, or N*2.5 V
// - between exit and full: programmed constant current
// - near full: constant voltage, current tapers
// - cv and current under 100 mA: full
// - restart below full minus N*0.1 V
// - converter switches at 250 kHz
// - 2 to 5 cells scale thresholds
// - 2.4 V 30 ms overcurrent, 2.2 V 40 us short
// - activation variant: discharge waits for charger
// - grounded chemistry select means iron phosphate
`timescale 1ns/1ps
module charge_phase_seq
   import charge_seq_pkg::*;
#(
   parameter int unsigned OC_CYCLES  = OC_CYC,
   parameter bit          ACTIVATION = 1'b1
)
(
   input  wire logic        i_sys_clk,
   input  wire logic        i_rst_n,
   input  wire logic        i_sample,       // adc strobe
   input  wire meas_t       i_meas,         // adc sample set
   input  wire logic [2:0]  i_cell_count,   // series cells
   input  wire logic [12:0] i_full_mv,      // full level per cell
   input  wire logic [15:0] i_cc_ma,        // constant current set
   input  wire logic [7:0]  i_duty,         // loop duty, of 200
   input  wire logic        i_cell_chemistry_select, // pin
   input  wire logic        i_charger_in,   // pin, adapter present
   input  wire logic        i_dsg_req,      // discharge wanted
   output phase_t           o_phase,
   output logic [15:0]      o_ichg_ma,      // current target
   output logic [15:0]      o_vreg_mv,      // voltage target
   output logic             o_cv_mode,
   output logic             o_full,
   output logic             o_cfg_err,
   output logic             o_sw_high,
   output logic             o_sw_low,
   output logic             o_dsg_en,
   output fault_t           o_fault
);
   // ==========================================================
   // pin synchronisers
   logic [1:0] chem_sync_r;   // chemistry select pin
   logic [1:0] chg_sync_r;    // charger present pin
   logic       lfp;           // iron phosphate chosen
   logic       chg_in;        // synchronised charger present

   // two stages each, only stage two is read
   always_ff @(posedge i_sys_clk)
   begin
      if (!i_rst_n)
      begin
         chem_sync_r <= 2'h3;
         chg_sync_r  <= 2'h0;
      end
      else
      begin
         chem_sync_r <= {chem_sync_r[0], i_cell_chemistry_select};
         chg_sync_r  <= {chg_sync_r[0], i_charger_in};
      end
   end

   assign lfp    = !chem_sync_r[1];
   assign chg_in = chg_sync_r[1];

   // ==========================================================
   // latest sample and scaled thresholds
   meas_t       meas_r;        // held sample
   logic        cells_ok;      // cell count in range
   logic [15:0] exit_mv;       // precharge exit level
   logic [15:0] full_mv;       // full charge level
   logic [15:0] cv_mv;         // cv entry level
   logic [15:0] rech_mv;       // restart level
   logic [N_COND-1:0] cond;    // raw conditions
   logic [N_COND-1:0] filt;    // persisted conditions

   // sample capture
   always_ff @(posedge i_sys_clk)
   begin
      if (!i_rst_n)
         meas_r <= '0;
      else if (i_sample)
         meas_r <= i_meas;
   end

   // per-cell figure times cell count, fits 16 bits at 5 cells
   function automatic logic [15:0] scale(input logic [2:0] n,
                                         input logic [12:0] mv);
      scale = 16'(n) * 16'(mv);
   endfunction

   assign cells_ok = (i_cell_count >= CELL_MIN) &&
                     (i_cell_count <= CELL_MAX);
   assign exit_mv = scale(i_cell_count, lfp ? EXIT_LFP_MV : EXIT_LI_MV);
   assign full_mv = scale(i_cell_count, i_full_mv);
   assign cv_mv   = full_mv - scale(i_cell_count, CV_WIN_MV);
   assign rech_mv = full_mv - scale(i_cell_count, RECH_DROP_MV);

   // conditions read from the live bus, judged only on the strobe
   always_comb
   begin
      cond               = '0;
      cond[C_ABOVE_LOW]  = i_meas.vbat_mv > VBAT_LOW_MV;
      cond[C_ABOVE_EXIT] = i_meas.vbat_mv > exit_mv;
      cond[C_NEAR_FULL]  = i_meas.vbat_mv >= cv_mv;
      cond[C_TERM_CUR]   = i_meas.ibat_ma < TERM_MA;
      cond[C_DROOP]      = i_meas.vbat_mv < rech_mv;
   end

   for (genvar g = 0; g < N_COND; g++)
   begin : g_persist
      sample_persist #(.COUNT(PERSIST_SAMPLES)) u_persist
      (
         .i_sys_clk (i_sys_clk),
         .i_rst_n   (i_rst_n),
         .i_sample  (i_sample),
         .i_cond    (cond[g]),
         .o_level   (filt[g])
      );
   end

   // ==========================================================
   // phase machine
   phase_t phase_r;    // current phase
   phase_t phase_nxt;  // next phase

   // climbs one step at a time so a rise in vbat passes each phase
   always_comb
   begin
      phase_nxt = phase_r;
      case (phase_r)
         PH_PRE_LOW:
            if (filt[C_ABOVE_LOW])
               phase_nxt = PH_PRE_HIGH;
         PH_PRE_HIGH:
            if (!filt[C_ABOVE_LOW])
               phase_nxt = PH_PRE_LOW;
            else if (filt[C_ABOVE_EXIT])
               phase_nxt = PH_CC;
         PH_CC:
            if (!filt[C_ABOVE_EXIT])
               phase_nxt = PH_PRE_HIGH;
            else if (filt[C_NEAR_FULL])
               phase_nxt = PH_CV;
         PH_CV:
            if (filt[C_TERM_CUR] && filt[C_NEAR_FULL])
               phase_nxt = PH_FULL;
            else if (!filt[C_ABOVE_EXIT])
               phase_nxt = PH_PRE_HIGH;
         PH_FULL:
            if (filt[C_DROOP])
               phase_nxt = filt[C_ABOVE_EXIT] ? PH_CC : PH_PRE_LOW;
         default:
            phase_nxt = PH_PRE_LOW;
      endcase
   end

   // phase register; no charger or bad cell count parks low precharge, full holds
   always_ff @(posedge i_sys_clk)
   begin
      if (!i_rst_n)
         phase_r <= PH_PRE_LOW;
      else if (!chg_in || !cells_ok)
         phase_r <= (phase_r == PH_FULL) ? PH_FULL : PH_PRE_LOW;
      else
         phase_r <= phase_nxt;
   end

   // ==========================================================
   // regulation targets, registered
   logic [15:0] ichg_r;   // current target
   logic [15:0] vreg_r;   // voltage target
   logic        active;   // converter allowed to switch

   assign active = chg_in && cells_ok && (phase_r != PH_FULL);

   // current target follows the phase one cycle later, voltage target tracks full_mv
   always_ff @(posedge i_sys_clk)
   begin
      if (!i_rst_n)
      begin
         ichg_r <= 16'h0000;
         vreg_r <= 16'h0000;
      end
      else
      begin
         vreg_r <= full_mv;
         if (!active)
            ichg_r <= 16'h0000;
         else
            case (phase_r)
               PH_PRE_LOW:  ichg_r <= PRE_LOW_MA;
               PH_PRE_HIGH: ichg_r <= PRE_HIGH_MA;
               PH_CC:       ichg_r <= i_cc_ma;
               // cc is only the ceiling, voltage loop tapers
               PH_CV:       ichg_r <= i_cc_ma;
               default:     ichg_r <= 16'h0000;
            endcase
      end
   end

   // ==========================================================
   // switching clock, 200 cycles per period
   logic [7:0] sw_cnt_r;    // position within period
   logic       sw_high_r;   // high-side gate
   logic       sw_low_r;    // low-side gate

   // fixed period counter and gate drive
   always_ff @(posedge i_sys_clk)
   begin
      if (!i_rst_n)
      begin
         sw_cnt_r  <= 8'h00;
         sw_high_r <= 1'b0;
         sw_low_r  <= 1'b0;
      end
      else
      begin
         if (sw_cnt_r == 8'(SW_PERIOD_CYC - 1))
            sw_cnt_r <= 8'h00;
         else
            sw_cnt_r <= sw_cnt_r + 8'h01;
         // never both on; low side idles off when stopped
         sw_high_r <= active && (sw_cnt_r < i_duty);
         sw_low_r  <= active && !(sw_cnt_r < i_duty);
      end
   end

   // ==========================================================
   // discharge supervision
   logic [20:0] oc_cnt_r;   // time below 2.4 V
   logic [11:0] sc_cnt_r;   // time below 2.2 V
   fault_t      fault_r;    // latched faults
   logic        armed_r;    // activation seen
   logic        dsg_r;      // discharge enable
   logic        low_oc;     // vout under overcurrent level
   logic        low_sc;     // vout under short level

   assign low_oc = dsg_r && (meas_r.vout_mv < OC_MV);
   assign low_sc = dsg_r && (meas_r.vout_mv < SC_MV);

   always_ff @(posedge i_sys_clk)
   begin
      if (!i_rst_n)
      begin
         oc_cnt_r <= 21'h000000;
         sc_cnt_r <= 12'h000;
      end
      else
      begin
         oc_cnt_r <= low_oc ? oc_cnt_r + 21'h000001 : 21'h000000;
         sc_cnt_r <= low_sc ? sc_cnt_r + 12'h001 : 12'h000;
      end
   end

   // faults latch until a charger restart; set wins
   always_ff @(posedge i_sys_clk)
   begin
      if (!i_rst_n)
         fault_r <= '0;
      else
      begin
         if (chg_in)
            fault_r <= '0;
         if (low_oc && oc_cnt_r == 21'(OC_CYCLES - 1))
            fault_r.overcur <= 1'b1;
         if (low_sc && sc_cnt_r == 12'(SC_CYC - 1))
            fault_r.short_ckt <= 1'b1;
      end
   end

   // activation latch, set once a charger is seen
   always_ff @(posedge i_sys_clk)
   begin
      if (!i_rst_n)
         armed_r <= 1'b0;
      else if (chg_in || !ACTIVATION)
         armed_r <= 1'b1;
   end

   always_ff @(posedge i_sys_clk)
   begin
      if (!i_rst_n)
         dsg_r <= 1'b0;
      else
         dsg_r <= i_dsg_req && armed_r && cells_ok && (fault_r == '0)
                  && !(low_sc && sc_cnt_r == 12'(SC_CYC - 1))
                  && !(low_oc && oc_cnt_r == 21'(OC_CYCLES - 1));
   end

   // ==========================================================
   // outputs
   assign o_phase   = phase_r;
   assign o_ichg_ma = ichg_r;
   assign o_vreg_mv = vreg_r;
   assign o_cv_mode = (phase_r == PH_CV);
   assign o_full    = (phase_r == PH_FULL);
   assign o_cfg_err = !cells_ok;
   assign o_sw_high = sw_high_r;
   assign o_sw_low  = sw_low_r;
   assign o_dsg_en  = dsg_r;
   assign o_fault   = fault_r;

   // ==========================================================
   // checks
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_rst_n);

   sequence s_in_cv_term;
      phase_r == PH_CV && filt[C_TERM_CUR] && filt[C_NEAR_FULL]
      && chg_in && cells_ok;
   endsequence

   pre_low_cur_a: assert property (
      phase_r == PH_PRE_LOW && active |=> ichg_r == PRE_LOW_MA)
      else $error("low precharge current wrong");
   pre_high_cur_a: assert property (
      phase_r == PH_PRE_HIGH && active |=> ichg_r == PRE_HIGH_MA)
      else $error("high precharge current wrong");
   term_to_full_a: assert property (
      s_in_cv_term |=> phase_r == PH_FULL ##1 ichg_r == 16'h0000)
      else $error("termination did not stop charge");
   full_hold_a: assert property (
      phase_r == PH_FULL && !filt[C_DROOP] |=> phase_r == PH_FULL)
      else $error("left full without droop");
   sw_period_a: assert property (
      sw_cnt_r == 8'h00 |=> sw_cnt_r != 8'h00 [*8])
      else $error("switching period too short");
   short_time_a: assert property (
      low_sc && sc_cnt_r == 12'(SC_CYC - 1) |=> fault_r.short_ckt
      ##0 !dsg_r)
      else $error("short fault timing wrong");
   fault_hold_a: assert property (
      fault_r != '0 && !chg_in |=> !dsg_r && fault_r != '0)
      else $error("discharge on during fault");
   activation_a: assert property (
      !armed_r |=> !dsg_r)
      else $error("discharge before activation");
   // low precharge is left only after the above-low filter level
   phase_step_a: assert property (
      phase_r == PH_PRE_LOW && !filt[C_ABOVE_LOW] |=> phase_r == PH_PRE_LOW)
      else $error("phase moved without cause");
endmodule

// ==== tb/battery_pack_model.sv ====
/*
 behavioural battery pack and charging adapter for the sequencer.
 assumes the bench sets the pack levels; one adc set every 8 clocks.
*/
`timescale 1ns/1ps
module battery_pack_model
   import charge_seq_pkg::*;
(
   input  wire logic        i_sys_clk,
   input  wire logic        i_rst_n,
   input  wire logic [15:0] i_vbat_mv,  // pack voltage
   input  wire logic [15:0] i_ibat_ma,  // pack current
   input  wire logic [15:0] i_vout_mv,  // discharge rail
   input  wire logic        i_lfp,      // iron phosphate pack fitted
   input  wire logic        i_plug,     // adapter plugged in
   output logic             o_sample,
   output meas_t            o_meas,
   output logic             o_chem_pin,
   output logic             o_charger
);
   logic [2:0] tick_r;  // strobe divider

   // ==========================================================
   // adc strobe
   // one clock in eight, so persistence takes about 32 clocks
   always_ff @(posedge i_sys_clk)
   begin
      if (!i_rst_n)
      begin
         tick_r   <= 3'h0;
         o_sample <= 1'b0;
      end
      else
      begin
         tick_r   <= tick_r + 3'h1;
         o_sample <= (tick_r == 3'h7);
      end
   end

   // sample set loaded with the strobe, held like a result register
   always_ff @(posedge i_sys_clk)
   begin
      if (tick_r == 3'h7)
      begin
         o_meas <= {i_vbat_mv, i_ibat_ma, i_vout_mv};
      end
   end

   // ==========================================================
   // pins
   // grounded for iron
   assign o_chem_pin = !i_lfp;
   assign o_charger  = i_plug;
endmodule

// ==== tb/tb_charge_phase_seq.sv ====
/*
 self-checking bench for the charge phase sequencer.
 assumes battery_pack_model on the far side and a 50 MHz clock.
*/
`timescale 1ns/1ps
module tb_charge_phase_seq import charge_seq_pkg::*;;
   logic        sys_clk;
   logic        rst_n;
   logic [15:0] vbat, ibat, vout;  // pack levels
   logic        lfp, plug, dsg_req;
   logic [2:0]  cells;
   logic [12:0] full_mv;
   logic [15:0] cc_ma;
   logic [7:0]  duty;
   logic        sample, chem_pin, charger;
   meas_t       meas;
   phase_t      phase;
   logic [15:0] ichg, vreg;
   logic        cv_mode, full, cfg_err, sw_hi, sw_lo, dsg_en;
   fault_t      fault;
   int          n_mismatch, compares, cyc;

   battery_pack_model u_battery_pack_model (.i_sys_clk(sys_clk),
      .i_rst_n(rst_n), .i_vbat_mv(vbat), .i_ibat_ma(ibat),
      .i_vout_mv(vout), .i_lfp(lfp), .i_plug(plug), .o_sample(sample),
      .o_meas(meas), .o_chem_pin(chem_pin), .o_charger(charger));

   // overcurrent count past the short time, so a short can trip first
   charge_phase_seq #(.OC_CYCLES(2500), .ACTIVATION(1'b1)) u_charge_phase_seq
   (
      .i_sys_clk(sys_clk), .i_rst_n(rst_n), .i_sample(sample),
      .i_meas(meas), .i_cell_count(cells), .i_full_mv(full_mv),
      .i_cc_ma(cc_ma), .i_duty(duty), .i_cell_chemistry_select(chem_pin),
      .i_charger_in(charger), .i_dsg_req(dsg_req), .o_phase(phase),
      .o_ichg_ma(ichg), .o_vreg_mv(vreg), .o_cv_mode(cv_mode),
      .o_full(full), .o_cfg_err(cfg_err), .o_sw_high(sw_hi),
      .o_sw_low(sw_lo), .o_dsg_en(dsg_en), .o_fault(fault)
   );

   // ==========================================================
   // clock and hang guard
   always #10 sys_clk = ~sys_clk;

   // ceiling well above the roughly 6000 clocks the tests need
   always @(posedge sys_clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         n_mismatch++;
         complete_run();
      end
   end

   // ==========================================================
   // shared tasks
   task automatic complete_run();
      $display("compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("BAD at %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(negedge sys_clk);
   endtask

   // new pack levels, launched just after an edge
   task automatic drive(input logic [15:0] v, input logic [15:0] i);
      @(posedge sys_clk);
      vbat <= v;
      ibat <= i;
   endtask

   // bounded wait, then a settle so the current target has landed
   task automatic wait_phase(input phase_t exp, input int lim);
      int k;
      k = 0;
      while (phase !== exp && k < lim)
      begin
         @(negedge sys_clk);
         k++;
      end
      tick(3);
      check({11'h000, phase}, {11'h000, exp});
   endtask

   task automatic do_reset(input logic iron, input logic plugged);
      @(posedge sys_clk);
      rst_n   <= 1'b0;
      lfp     <= iron;
      plug    <= plugged;
      dsg_req <= 1'b0;
      vbat    <= 16'h07D0;
      ibat    <= 16'h01F4;
      vout    <= 16'h1388;
      repeat (8) @(posedge sys_clk);
      rst_n <= 1'b1;
   endtask

   // ==========================================================
   // scenarios
   task automatic t_precharge();
      do_reset(1'b0, 1'b1);
      drive(16'h09C4, 16'h01F4);
      tick(80);
      wait_phase(PH_PRE_LOW, 0);
      check(ichg, 16'h0064);
      // one or two samples above the level must not move the phase
      drive(16'h09C5, 16'h01F4);
      tick(10);
      drive(16'h09C4, 16'h01F4);
      tick(40);
      wait_phase(PH_PRE_LOW, 0);
      drive(16'h09C5, 16'h01F4);
      wait_phase(PH_PRE_HIGH, 100);
      check(ichg, 16'h00C8);
      $display("precharge test done");
   endtask

   // walks the whole ladder from the precharge test's state
   task automatic t_ladder();
      drive(16'h2328, 16'h01F4);
      tick(80);
      wait_phase(PH_PRE_HIGH, 0);
      drive(16'h2329, 16'h01F4);
      wait_phase(PH_CC, 100);
      check(ichg, cc_ma);
      check(vreg, 16'h3138);
      drive(16'h3138, 16'h01F4);
      wait_phase(PH_CV, 100);
      check({15'h0, cv_mode}, 16'h0001);
      drive(16'h3138, 16'h0032);
      wait_phase(PH_FULL, 100);
      check({15'h0, full}, 16'h0001);
      drive(16'h303E, 16'h0000);
      tick(80);
      wait_phase(PH_FULL, 0);
      drive(16'h300B, 16'h01F4);
      wait_phase(PH_CC, 100);
      $display("ladder test done");
   endtask

   task automatic t_chem();
      do_reset(1'b1, 1'b1);
      drive(16'h1D4C, 16'h01F4);
      wait_phase(PH_PRE_HIGH, 100);
      tick(80);
      wait_phase(PH_PRE_HIGH, 0);
      drive(16'h1D4D, 16'h01F4);
      wait_phase(PH_CC, 100);
      $display("chemistry test done");
   endtask

   task automatic t_cells();
      logic [2:0]  tab [4] = '{3'h1, 3'h2, 3'h5, 3'h6};
      logic        bad;
      do_reset(1'b0, 1'b1);
      for (int j = 0; j < 4; j++)
      begin
         @(posedge sys_clk);
         cells <= tab[j];
         tick(6);
         bad = (tab[j] < 3'h2) || (tab[j] > 3'h5);
         check({15'h0, cfg_err}, {15'h0, bad});
         if (bad)
            check(ichg, 16'h0000);
         else
            check(vreg, 16'(tab[j]) * 16'h1068);
      end
      @(posedge sys_clk);
      cells <= 3'h3;
      $display("cell count test done");
   endtask

   task automatic t_switch();
      int hi, both, first, last, prev;
      hi = 0;
      both = 0;
      first = -1;
      last = 0;
      do_reset(1'b0, 1'b1);
      drive(16'h1388, 16'h01F4);
      @(posedge sys_clk);
      duty <= 8'h32;
      tick(20);
      prev = sw_hi;
      // two whole periods: rise spacing and on time both show
      for (int k = 0; k < 400; k++)
      begin
         @(negedge sys_clk);
         hi += sw_hi;
         both += sw_hi & sw_lo;
         if (sw_hi && !prev)
         begin
            if (first < 0)
               first = k;
            else
               last = k;
         end
         prev = sw_hi;
      end
      check(16'(hi), 16'h0064);
      check(16'(last - first), 16'h00C8);
      check(16'(both), 16'h0000);
      $display("switching test done");
   endtask

   task automatic t_discharge();
      do_reset(1'b0, 1'b0);
      @(posedge sys_clk);
      dsg_req <= 1'b1;
      tick(100);
      check({15'h0, dsg_en}, 16'h0000);
      @(posedge sys_clk);
      plug <= 1'b1;
      tick(10);
      check({15'h0, dsg_en}, 16'h0001);
      @(posedge sys_clk);
      plug <= 1'b0;
      tick(10);
      check({15'h0, dsg_en}, 16'h0001);
      @(posedge sys_clk);
      vout <= 16'h08FC;
      tick(2400);
      check({15'h0, fault.overcur}, 16'h0000);
      tick(150);
      check({15'h0, fault.overcur}, 16'h0001);
      check({15'h0, dsg_en}, 16'h0000);
      @(posedge sys_clk);
      vout <= 16'h1388;
      tick(100);
      check({15'h0, dsg_en}, 16'h0000);
      @(posedge sys_clk);
      plug <= 1'b1;
      tick(10);
      check({14'h0, fault}, 16'h0000);
      check({15'h0, dsg_en}, 16'h0001);
      @(posedge sys_clk);
      plug <= 1'b0;
      vout <= 16'h07D0;
      tick(1900);
      check({15'h0, fault.short_ckt}, 16'h0000);
      tick(150);
      check({15'h0, fault.short_ckt}, 16'h0001);
      check({15'h0, fault.overcur}, 16'h0000);
      check({15'h0, dsg_en}, 16'h0000);
      $display("discharge test done");
   endtask

   // ==========================================================
   // main sequence
   initial
   begin
      sys_clk = 1'b0;
      rst_n = 1'b0;
      vbat = 16'h07D0;
      ibat = 16'h01F4;
      vout = 16'h1388;
      lfp = 1'b0;
      plug = 1'b1;
      dsg_req = 1'b0;
      cells = 3'h3;
      full_mv = 13'h1068;
      cc_ma = 16'h07D0;
      duty = 8'h32;
      n_mismatch = 0;
      compares = 0;
      cyc = 0;
      t_precharge();
      t_ladder();
      t_chem();
      t_cells();
      t_switch();
      t_discharge();
      complete_run();
   end
endmodule
